// ===== inc/pfsb_pkg.sv
// pfsb_pkg: command codes, bit positions and reset values for the fault status bytes
// assumes a byte-wide command port from an outside bus engine on the same clock
package pfsb_pkg;
  // command codes
  localparam logic [7:0] CMD_IOUT      = 8'h7b;
  localparam logic [7:0] CMD_INPUT     = 8'h7c;
  localparam logic [7:0] CMD_TEMP      = 8'h7d;
  // output current byte
  localparam int         OC_FAULT_BIT  = 7;
  localparam int         OC_WARN_BIT   = 5;
  localparam int         UC_FAULT_BIT  = 4;
  // input byte
  localparam int         OV_FAULT_BIT  = 7;
  localparam int         UV_WARN_BIT   = 5;
  localparam int         LOW_IN_BIT    = 3;
  // temperature byte
  localparam int         OT_FAULT_BIT  = 7;
  localparam int         OT_WARN_BIT   = 6;
  // summary word
  localparam int         SUM_IOUT_BIT  = 14;
  localparam int         SUM_INPUT_BIT = 13;
  // reset values
  localparam logic [7:0] STATUS_RST    = 8'h00;
  localparam logic [7:0] SYNC_RST      = 8'h00;
  localparam logic       LOW_IN_RST    = 1'h1;
  localparam logic       ARMED_RST     = 1'h0;
  localparam logic       BIT_RST       = 1'h0;
  localparam logic [15:0] SUMMARY_RST  = 16'h0000;
  // number of latched flags: current fault and warn, undercurrent, input over and under,
  // temperature fault and warn
  localparam int         NFLAG         = 7;
  localparam logic [6:0] FLAG_RST      = 7'h00;
endpackage : pfsb_pkg

// ===== hdl/pfsb_status.sv
// pfsb_status: latched fault status bytes for output current, input and temperature
// assumes a bus engine on i_clk presents byte reads, byte writes and clear-faults;
// detector event inputs come from the analog side and are synchronised here
`timescale 1ns/10ps

// Functional notes
// - output current byte at 7bh, byte read/write
// - clear-faults or write one clears flags
// - bit 7 latches output overcurrent fault
// - bit 5 latches output overcurrent warning
// - undercurrent bit 4 settled: reads zero
// - bit 6 and 3:0 read zero
// - input byte 7ch bit 7 overvoltage latch
// - input bit 5 undervoltage warning latch
// - input bits 6, 4, 2:0 read zero
// - input bit 3 live input-off indication
// - low-input set when blocked, never alerts
// - low-input set from reset without alert
// - undervoltage warning may raise alert, masked
// - undervoltage warning suppressed until first turn-on
// - temperature byte 7dh bit 7 fault latch
// - temperature bit 6 warning latch
// - every alerting bit has a mask bit
// - summary bit 14 from output current flags
// - summary bit 13 from input flags
module pfsb_status
(
  // clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_nrst,
  // command port from the bus engine
  input  wire logic [7:0]               i_cmd,
  input  wire logic                     i_wr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_rd,
  input  wire logic                     i_clear_faults,
  output logic      [7:0]               o_rdata,
  output logic                          o_rvalid,
  // detector events (asynchronous levels)
  input  wire logic                     i_out_oc_fault,
  input  wire logic                     i_out_oc_warn,
  input  wire logic                     i_in_ov_fault,
  input  wire logic                     i_in_uv_warn,
  input  wire logic                     i_ot_fault,
  input  wire logic                     i_ot_warn,
  input  wire logic                     i_power_input_rail_on,
  input  wire logic                     i_internal_bias_rail_ok,
  // alert mask, one bit per latched flag, from the mask register outside
  input  wire logic [pfsb_pkg::NFLAG-1:0] i_alert_mask,
  // status outputs
  output logic                          o_alert,
  output logic      [15:0]              o_summary
);

  // flag index order: 0 current fault, 1 current warn, 2 undercurrent, 3 input over,
  // 4 input under, 5 temperature fault, 6 temperature warn
  localparam int NSYNC = 8;

  logic [NSYNC-1:0]          raw_in;
  logic [NSYNC-1:0]          s1_q;
  logic [NSYNC-1:0]          s2_q;
  logic [NSYNC-1:0]          s_d1;
  logic [NSYNC-1:0]          s_d2;
  logic [pfsb_pkg::NFLAG-1:0] flag_q;
  logic [pfsb_pkg::NFLAG-1:0] flag_d;
  logic [pfsb_pkg::NFLAG-1:0] evt;
  logic [pfsb_pkg::NFLAG-1:0] wclr;
  logic                      low_in_q;
  logic                      low_in_d;
  logic                      armed_q;
  logic                      armed_d;
  logic [7:0]                rdata_d;
  logic                      rvalid_d;
  logic                      alert_d;
  logic [15:0]               summary_d;
  logic [7:0]                iout_byte;
  logic [7:0]                input_byte;
  logic [7:0]                temp_byte;

  assign raw_in = {i_internal_bias_rail_ok, i_power_input_rail_on, i_ot_warn, i_ot_fault,
                   i_in_uv_warn, i_in_ov_fault, i_out_oc_warn, i_out_oc_fault};

  // two-flop synchronisers; only the second stage is read by logic
  always_comb
  begin
    s_d1 = raw_in;
    s_d2 = s1_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      s1_q <= pfsb_pkg::SYNC_RST;
      s2_q <= pfsb_pkg::SYNC_RST;
    end
    else
    begin
      s1_q <= s_d1;
      s2_q <= s_d2;
    end
  end

  // undercurrent fault has no detector; its flag never sets, so bit 4 reads zero
  always_comb
  begin
    evt    = '0;
    evt[0] = s2_q[0];
    evt[1] = s2_q[1];
    evt[2] = 1'b0;
    evt[3] = s2_q[2];
    evt[4] = s2_q[3] & armed_q;
    evt[5] = s2_q[4];
    evt[6] = s2_q[5];
  end

  // per-flag write-one-to-clear decode; zeros and unsupported bits do nothing
  always_comb
  begin
    wclr = '0;
    if (i_wr)
    begin
      case (i_cmd)
        pfsb_pkg::CMD_IOUT:
        begin
          wclr[0] = i_wdata[pfsb_pkg::OC_FAULT_BIT];
          wclr[1] = i_wdata[pfsb_pkg::OC_WARN_BIT];
          wclr[2] = i_wdata[pfsb_pkg::UC_FAULT_BIT];
        end
        pfsb_pkg::CMD_INPUT:
        begin
          wclr[3] = i_wdata[pfsb_pkg::OV_FAULT_BIT];
          wclr[4] = i_wdata[pfsb_pkg::UV_WARN_BIT];
        end
        pfsb_pkg::CMD_TEMP:
        begin
          wclr[5] = i_wdata[pfsb_pkg::OT_FAULT_BIT];
          wclr[6] = i_wdata[pfsb_pkg::OT_WARN_BIT];
        end
        default:
        begin
          wclr = '0;
        end
      endcase
    end
  end

  // a detector event in the clearing cycle wins, so no event is lost
  always_comb
  begin
    for (int i = 0; i < pfsb_pkg::NFLAG; i++)
    begin
      flag_d[i] = evt[i] | (flag_q[i] & ~(wclr[i] | i_clear_faults));
    end
  end

  // low input is live: blocked by input below turn-on or bias under lockout
  always_comb
  begin
    low_in_d = ~s2_q[6] | ~s2_q[7];
    armed_d  = armed_q | s2_q[6];
  end

  always_comb
  begin
    iout_byte = '0;
    iout_byte[pfsb_pkg::OC_FAULT_BIT] = flag_q[0];
    iout_byte[pfsb_pkg::OC_WARN_BIT]  = flag_q[1];
    iout_byte[pfsb_pkg::UC_FAULT_BIT] = flag_q[2];
    input_byte = '0;
    input_byte[pfsb_pkg::OV_FAULT_BIT] = flag_q[3];
    input_byte[pfsb_pkg::UV_WARN_BIT]  = flag_q[4];
    input_byte[pfsb_pkg::LOW_IN_BIT]   = low_in_q;
    temp_byte = '0;
    temp_byte[pfsb_pkg::OT_FAULT_BIT] = flag_q[5];
    temp_byte[pfsb_pkg::OT_WARN_BIT]  = flag_q[6];
  end

  // read answer one cycle after the request; unknown codes answer zero
  always_comb
  begin
    rvalid_d = i_rd;
    case (i_cmd)
      pfsb_pkg::CMD_IOUT:  rdata_d = iout_byte;
      pfsb_pkg::CMD_INPUT: rdata_d = input_byte;
      pfsb_pkg::CMD_TEMP:  rdata_d = temp_byte;
      default:             rdata_d = 8'h00;
    endcase
    if (!i_rd)
    begin
      rdata_d = o_rdata;
    end
  end

  // low input is left out of the alert; only latched flags reach it
  always_comb
  begin
    alert_d = |(flag_q & ~i_alert_mask);
    summary_d = '0;
    summary_d[pfsb_pkg::SUM_IOUT_BIT]  = |flag_q[2:0];
    summary_d[pfsb_pkg::SUM_INPUT_BIT] = |flag_q[4:3] | low_in_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      flag_q    <= pfsb_pkg::FLAG_RST;
      low_in_q  <= pfsb_pkg::LOW_IN_RST;
      armed_q   <= pfsb_pkg::ARMED_RST;
      o_rdata   <= pfsb_pkg::STATUS_RST;
      o_rvalid  <= pfsb_pkg::BIT_RST;
      o_alert   <= pfsb_pkg::BIT_RST;
      o_summary <= pfsb_pkg::SUMMARY_RST;
    end
    else
    begin
      flag_q    <= flag_d;
      low_in_q  <= low_in_d;
      armed_q   <= armed_d;
      o_rdata   <= rdata_d;
      o_rvalid  <= rvalid_d;
      o_alert   <= alert_d;
      o_summary <= summary_d;
    end
  end

  // checks
  a_flag_latch: assert property (@(posedge i_clk) disable iff (!i_nrst)
    s2_q[0] |=> flag_q[0])
    else $error("overcurrent fault not latched");

  a_flag_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (flag_q[5] && !s2_q[4] && !i_clear_faults && !(i_wr && i_cmd == pfsb_pkg::CMD_TEMP))
    |=> flag_q[5])
    else $error("fault flag dropped without clear");

  a_clear_all: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_clear_faults && evt == '0) |=> flag_q == '0)
    else $error("clear-faults left a flag set");

  a_ucf_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_rvalid |-> (o_rdata[4] == 1'b0 || $past(i_cmd) != pfsb_pkg::CMD_IOUT))
    else $error("undercurrent bit not zero");

  a_iout_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_rd && i_cmd == pfsb_pkg::CMD_IOUT) |=> o_rvalid && o_rdata[7] == $past(flag_q[0])
      && o_rdata[6] == 1'b0 && o_rdata[3:0] == 4'h0)
    else $error("output current read wrong");

  a_uvw_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !armed_q |-> ##1 !flag_q[4] || $past(flag_q[4]))
    else $error("undervoltage warning before first turn-on");

  a_low_alert: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (flag_q == '0) |=> !o_alert)
    else $error("alert without latched flag");

  a_mask_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ((flag_q & ~i_alert_mask) != '0) |=> o_alert)
    else $error("unmasked flag did not alert");

  a_low_live: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!s2_q[6]) |=> low_in_q)
    else $error("low input not shown");

  a_sum_iout: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (|flag_q[2:0]) |=> o_summary[pfsb_pkg::SUM_IOUT_BIT])
    else $error("summary current bit missing");

  a_warn_latch: assert property (@(posedge i_clk) disable iff (!i_nrst)
    s2_q[1] |=> flag_q[1])
    else $error("overcurrent warning not latched");

  a_overvolt_latch: assert property (@(posedge i_clk) disable iff (!i_nrst)
    s2_q[2] |=> flag_q[3])
    else $error("input overvoltage fault not latched");

  a_undervolt_latch: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s2_q[3] && armed_q) |=> flag_q[4])
    else $error("input undervoltage warning not latched");

  a_heat_fault: assert property (@(posedge i_clk) disable iff (!i_nrst)
    s2_q[4] |=> flag_q[5])
    else $error("overtemperature fault not latched");

  a_heat_warn: assert property (@(posedge i_clk) disable iff (!i_nrst)
    s2_q[5] |=> flag_q[6])
    else $error("overtemperature warning not latched");

  a_input_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_rd && i_cmd == pfsb_pkg::CMD_INPUT) |=> o_rvalid && o_rdata[7] == $past(flag_q[3])
      && o_rdata[5] == $past(flag_q[4]) && o_rdata[3] == $past(low_in_q)
      && o_rdata[6] == 1'h0 && o_rdata[4] == 1'h0 && o_rdata[2:0] == 3'h0)
    else $error("input byte read wrong");

  a_temp_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_rd && i_cmd == pfsb_pkg::CMD_TEMP) |=> o_rvalid && o_rdata[7] == $past(flag_q[5])
      && o_rdata[6] == $past(flag_q[6]) && o_rdata[5:0] == 6'h00)
    else $error("temperature byte read wrong");

  a_unknown_read: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_rd && i_cmd != pfsb_pkg::CMD_IOUT && i_cmd != pfsb_pkg::CMD_INPUT
      && i_cmd != pfsb_pkg::CMD_TEMP) |=> o_rdata == 8'h00)
    else $error("unknown command read not zero");

  a_rvalid_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_rd |=> !o_rvalid)
    else $error("read valid without a read");

  a_rdata_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_rd |=> $stable(o_rdata))
    else $error("read data moved without a read");

  a_write_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_wr && i_cmd == pfsb_pkg::CMD_IOUT && i_wdata[7] && !s2_q[0]) |=> !flag_q[0])
    else $error("write one did not clear");

  a_zero_keep: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (flag_q[0] && !i_clear_faults
      && !(i_wr && i_cmd == pfsb_pkg::CMD_IOUT && i_wdata[7])) |=> flag_q[0])
    else $error("flag lost without a one written");

  a_mask_block: assert property (@(posedge i_clk) disable iff (!i_nrst)
    ((flag_q & ~i_alert_mask) == '0) |=> !o_alert)
    else $error("masked flag raised the alert");

  a_low_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (s2_q[6] && s2_q[7]) |=> !low_in_q)
    else $error("low input shown while converting");

  a_bias_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !s2_q[7] |=> low_in_q)
    else $error("low input missing under bias lockout");

  a_sum_input: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (|flag_q[4:3] || low_in_q) |=> o_summary[pfsb_pkg::SUM_INPUT_BIT])
    else $error("summary input bit missing");

  a_sum_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (flag_q == '0 && !low_in_q) |=> o_summary == pfsb_pkg::SUMMARY_RST)
    else $error("summary set without a flag");

  a_arm_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    armed_q |=> armed_q)
    else $error("undervoltage arming dropped");

endmodule : pfsb_status

// ===== testbench/pfsb_host.sv
// pfsb_host: host that makes byte reads, writes and clear-faults
// assumes the status block samples on the rising edge of i_clk
`timescale 1ns/10ps
module pfsb_host
(
  // clock
  input  wire logic       i_clk,
  // requests
  output logic      [7:0] o_cmd,
  output logic            o_wr,
  output logic      [7:0] o_wdata,
  output logic            o_rd,
  output logic            o_clr,
  // answer
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  initial
  begin
    o_cmd = 8'h00;
    o_wdata = 8'h00;
    {o_wr, o_rd, o_clr} = 3'h0;
  end
  // k is {write, read, clear}; released lines show inverted data, not the last value
  task automatic xfer(input logic [7:0] c, input logic [2:0] k, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge i_clk);
    o_cmd = c;
    o_wdata = d;
    {o_wr, o_rd, o_clr} = k;
    @(negedge i_clk);
    {o_wr, o_rd, o_clr} = 3'h0;
    o_cmd = ~c;
    o_wdata = ~d;
    for (int i = 0; i < 3; i++)
      if (k[1] && !i_rvalid) @(negedge i_clk);
    q = i_rvalid ? i_rdata : 8'hxx;
  endtask : xfer
endmodule : pfsb_host

// ===== testbench/pfsb_status_bench.sv
// pfsb_status_bench: random detector events, masks and clears against a flag model
// assumes pfsb_status and pfsb_host are compiled before this file
`timescale 1ns/10ps
module pfsb_status_bench;
  logic        clk, nrst, wr, rd, clr, rvalid, alert, rail, bias, low;
  logic [7:0]  cmd, wdata, rdata, q, c;
  logic [5:0]  ev;
  logic [6:0]  mask, f;
  logic [15:0] summary;
  logic [31:0] lfsr;
  int          errors, num_checks;

  pfsb_host host (.i_clk(clk), .o_cmd(cmd), .o_wr(wr), .o_wdata(wdata), .o_rd(rd),
    .o_clr(clr), .i_rdata(rdata), .i_rvalid(rvalid));
  pfsb_status DUT (.i_clk(clk), .i_nrst(nrst), .i_cmd(cmd), .i_wr(wr), .i_wdata(wdata),
    .i_rd(rd), .i_clear_faults(clr), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_out_oc_fault(ev[0]), .i_out_oc_warn(ev[1]), .i_in_ov_fault(ev[2]),
    .i_in_uv_warn(ev[3]), .i_ot_fault(ev[4]), .i_ot_warn(ev[5]),
    .i_power_input_rail_on(rail), .i_internal_bias_rail_ok(bias),
    .i_alert_mask(mask), .o_alert(alert), .o_summary(summary));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [7:0] xbyte(input logic [7:0] a, input logic [6:0] g, input logic l);
    case (a)
      8'h7b: return {g[0], 1'b0, g[1], 5'h00};
      8'h7c: return {g[3], 1'b0, g[4], 1'b0, l, 3'h0};
      8'h7d: return {g[5], g[6], 6'h00};
      default: return 8'h00;
    endcase
  endfunction : xbyte
  // only supported latched bits of the addressed byte react to ones
  function automatic logic [6:0] wclr(input logic [6:0] g, input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h7b: return g & ~{5'h00, d[5], d[7]};
      8'h7c: return g & ~{2'h0, d[5], d[7], 3'h0};
      8'h7d: return g & ~{d[6], d[7], 5'h00};
      default: return g;
    endcase
  endfunction : wclr

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want)
    begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic rdck(input logic [7:0] a);
    host.xfer(a, 3'b010, 8'h00, q);
    check(q, xbyte(a, f, low));
  endtask : rdck
  task automatic stck();
    check(alert, |(f & ~mask));
    check(summary, {1'b0, f[0] | f[1], f[3] | f[4] | low, 13'h0});
  endtask : stck
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  assign low = ~(rail & bias);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // 20000 cycles, far longer than 200 rounds of 16 cycles
  initial
  begin
    #400000;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    {nrst, rail, bias, ev, mask, f} = {3'b001, 6'h00, 7'h00, 7'h00};
    lfsr = 32'h43ba;
    repeat (2) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    check(alert, 1'b0);
    ev = 6'h08;
    repeat (5) @(negedge clk);
    ev = 6'h00;
    rdck(8'h7c);
    stck();
    rail = 1'b1;
    repeat (5) @(negedge clk);
    bias = 1'b0;
    repeat (5) @(negedge clk);
    rdck(8'h7c);
    stck();
    bias = 1'b1;
    repeat (5) @(negedge clk);
    for (int i = 0; i < 200; i++)
    begin
      lfsr = nxt(lfsr);
      ev = lfsr[5:0] & lfsr[11:6];
      mask = lfsr[18:12];
      f = f | {ev[5:2], 1'b0, ev[1:0]};
      repeat (2) @(negedge clk);
      ev = 6'h00;
      repeat (4) @(negedge clk);
      stck();
      c = 8'h7a + {6'h00, lfsr[20:19]};
      if (lfsr[23:22] == 2'h0)
      begin
        host.xfer(c, 3'b001, 8'h00, q);
        f = 7'h00;
      end
      else
      begin
        host.xfer(c, 3'b100, lfsr[31:24], q);
        f = wclr(f, c, lfsr[31:24]);
      end
      for (int k = 0; k < 4; k++)
        rdck(8'h7a + k[7:0]);
      stck();
    end
    // corner: clear-faults while the detector still stands; the event must win
    ev = 6'h01;
    repeat (4) @(negedge clk);
    host.xfer(8'h7b, 3'h1, 8'h00, q);
    f = 7'h01;
    rdck(8'h7b);
    ev = 6'h00;
    repeat (4) @(negedge clk);
    host.xfer(8'h7b, 3'h4, 8'h80, q);
    f = 7'h00;
    rdck(8'h7b);
    // second reset in mid-run with a flag latched
    ev = 6'h10;
    repeat (4) @(negedge clk);
    ev = 6'h00;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    f = 7'h00;
    check(alert, 1'h0);
    check(summary, 16'h0000);
    host.xfer(8'h7c, 3'h2, 8'h00, q);
    check(q, 8'h08);
    repeat (5) @(negedge clk);
    rdck(8'h7c);
    rdck(8'h7d);
    stck();
    tally_and_finish();
  end
endmodule : pfsb_status_bench
